// *** hw/dbsp_pkg.sv ***
/*
 * Shared constants for the burst SRAM port model: widths, depths and
 * reset values used by the port logic and its write buffer.
 * Assumes a single design clock; it depends on no other files.
 */
package dbsp_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int DATA_W = 18;     // Word width of the narrow part.
    localparam int ADDR_W = 20;     // Address bits decoded by the narrow part.
    localparam int LANE_W = 9;      // Bits covered by one lane mask bit.
    localparam int STORE_W = 4;     // Index bits of the flip-flop array.
    localparam int BURST_LEN = 2;   // Words moved by every access.

    // ------------------------------------------------------------
    // Buffering
    // ------------------------------------------------------------
    localparam int FIFO_DEPTH = 16; // Write entries held before the array.

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic RST_LOW = 1'h0; // Cleared control bit.

endpackage : dbsp_pkg

// *** hw/dbsp_port.sv ***
/*
 * Pin-level model of a two-word burst SRAM with separate read and write
 * ports, plus the write buffer that stands in front of its array.
 * Assumes every pin, clocks included, is asynchronous to clock_i, which
 * runs well above the link clocks so their edges can be found by sampling.
 */
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Write buffer
// ----------------------------------------------------------------
module dbsp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = dbsp_pkg::FIFO_DEPTH
) (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Filling side.
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Draining side.
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_reg [DEPTH];  // Entry storage.
    logic [PW-1:0] wp_reg;              // Next slot to fill.
    logic [PW-1:0] rp_reg;              // Next slot to drain.
    logic [PW:0] cnt_reg;               // Entries held.
    wire push = in_valid_i & in_ready_o;
    wire pop = out_valid_o & out_ready_i;
    assign in_ready_o = (cnt_reg != (PW+1)'(DEPTH));
    assign out_valid_o = (cnt_reg != '0);
    assign out_data_o = mem_reg[rp_reg];

    // Pointers and fill count move on accepted transfers only.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            wp_reg <= push ? wp_reg + 1'b1 : wp_reg;
            rp_reg <= pop ? rp_reg + 1'b1 : rp_reg;
            cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    // Storage is written without reset; only valid slots are ever read out.
    always_ff @(posedge clock_i)
    begin
        if (push)
        begin
            mem_reg[wp_reg] <= in_data_i;
        end
    end

endmodule : dbsp_fifo

module dbsp_port #(
    parameter int DATA_W = dbsp_pkg::DATA_W,
    parameter int ADDR_W = dbsp_pkg::ADDR_W,
    parameter int STORE_W = dbsp_pkg::STORE_W
) (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Input and output clocks and single clock strap.
    input wire logic primary_timing_pos_i,
    input wire logic primary_timing_neg_i,
    input wire logic output_timing_pos_i,
    input wire logic output_timing_neg_i,
    input wire logic single_clock_mode_i,
    // Selects, address and write data.
    input wire logic write_port_select_n_i,
    input wire logic read_port_select_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W/dbsp_pkg::LANE_W-1:0] byte_lane_mask_n_i,
    input wire logic [DATA_W-1:0] write_word_in_i,
    // Read data and echo clock.
    output logic [DATA_W-1:0] read_word_out_o,
    output logic read_word_oe_o,
    output logic echo_timing_o
);
    localparam int LANES = DATA_W / dbsp_pkg::LANE_W;
    localparam int PINS = 7 + LANES + ADDR_W + DATA_W;
    localparam int ENT_W = ADDR_W + 2 * (DATA_W + LANES);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [PINS-1:0] s1_reg;   // First stage, read only by the second.
    logic [PINS-1:0] s2_reg;   // Second stage, safe to use.
    logic [3:0] clk_d_reg;     // Previous clock levels for edge finding.

    // Every pin passes two flip-flops; clock levels get a third for edges.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            clk_d_reg <= '0;
        end
        else
        begin
            s1_reg <= {primary_timing_pos_i, primary_timing_neg_i, output_timing_pos_i,
                       output_timing_neg_i, single_clock_mode_i, write_port_select_n_i,
                       read_port_select_n_i, byte_lane_mask_n_i, addr_i, write_word_in_i};
            s2_reg <= s1_reg;
            clk_d_reg <= s2_reg[PINS-1 -: 4];
        end
    end

    // Unpacked synchronised pins.
    wire [3:0] clk_s = s2_reg[PINS-1 -: 4];
    wire single_s = s2_reg[PINS-5];
    wire wsel_n_s = s2_reg[PINS-6];
    wire rsel_n_s = s2_reg[PINS-7];
    wire [LANES-1:0] mask_n_s = s2_reg[DATA_W+ADDR_W +: LANES];
    wire [ADDR_W-1:0] addr_s = s2_reg[DATA_W +: ADDR_W];
    wire [DATA_W-1:0] data_s = s2_reg[DATA_W-1:0];
    // Rising edges of each sampled clock.
    wire [3:0] rise = clk_s & ~clk_d_reg;
    wire kp_rise = rise[3];
    wire kn_rise = rise[2];
    // Single clock mode moves read data on the input clocks.
    wire out_pos_rise = single_s ? rise[3] : rise[1];
    wire out_neg_rise = single_s ? rise[2] : rise[0];

    // ------------------------------------------------------------
    // Write port
    // ------------------------------------------------------------
    logic wr_open_reg;                // First half of a write is held.
    logic [DATA_W-1:0] w0_reg;        // First write word.
    logic [LANES-1:0] m0_reg;         // Its lane masks, active low.
    logic fifo_in_ready;              // Buffer has room for one entry.
    logic fifo_out_valid;             // Buffer holds an entry.
    logic [ENT_W-1:0] fifo_out;       // Oldest entry.
    // A write opens only with room in the buffer, so the second half can
    // never be refused; a full buffer makes the write be dropped whole.
    wire wr_start = kp_rise & ~wsel_n_s & fifo_in_ready;
    wire wr_push = kn_rise & wr_open_reg;
    wire [ENT_W-1:0] wr_entry = {addr_s, w0_reg, m0_reg, data_s, mask_n_s};
    // First word and masks are taken on the positive rise; a high select
    // closes the port so nothing of the bus is kept.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_open_reg <= dbsp_pkg::RST_LOW;
            w0_reg <= '0;
            m0_reg <= '1;
        end
        else if (kp_rise)
        begin
            wr_open_reg <= wr_start;
            w0_reg <= wr_start ? data_s : w0_reg;
            m0_reg <= wr_start ? mask_n_s : m0_reg;
        end
        else if (kn_rise)
        begin
            wr_open_reg <= dbsp_pkg::RST_LOW;
        end
    end

    // ------------------------------------------------------------
    // Array: two halves, one word of each burst in each
    // ------------------------------------------------------------
    logic [DATA_W-1:0] arr0_reg [2**STORE_W];  // First words.
    logic [DATA_W-1:0] arr1_reg [2**STORE_W];  // Second words.
    logic [ADDR_W-1:0] rd_addr_reg;            // Last read address.
    // A read fetch owns the array in its cycle and stalls the buffer.
    wire rd_fetch = kp_rise & ~rsel_n_s;
    wire drain = fifo_out_valid & ~rd_fetch;
    wire [STORE_W-1:0] wr_idx = fifo_out[ENT_W-ADDR_W +: STORE_W];
    wire [STORE_W-1:0] rd_idx = addr_s[STORE_W-1:0];
    wire [DATA_W-1:0] d0 = fifo_out[DATA_W+2*LANES +: DATA_W];
    wire [LANES-1:0] mk0 = fifo_out[DATA_W+LANES +: LANES];
    wire [DATA_W-1:0] d1 = fifo_out[LANES +: DATA_W];
    wire [LANES-1:0] mk1 = fifo_out[LANES-1:0];
    // Lane masks widened to one bit per data bit, high where a stored bit stays.
    wire [DATA_W-1:0] keep0;  // Keep mask of the first word.
    wire [DATA_W-1:0] keep1;  // Keep mask of the second word.
    for (genvar g = 0; g < LANES; g++)
    begin : g_lane
        assign keep0[g*dbsp_pkg::LANE_W +: dbsp_pkg::LANE_W] = {dbsp_pkg::LANE_W{mk0[g]}};
        assign keep1[g*dbsp_pkg::LANE_W +: dbsp_pkg::LANE_W] = {dbsp_pkg::LANE_W{mk1[g]}};
    end
    // One process writes each array; masked lanes keep their stored bits.
    always_ff @(posedge clock_i)
    begin
        if (drain)
        begin
            arr0_reg[wr_idx] <= (arr0_reg[wr_idx] & keep0) | (d0 & ~keep0);
            arr1_reg[wr_idx] <= (arr1_reg[wr_idx] & keep1) | (d1 & ~keep1);
        end
    end

    dbsp_fifo #(.WIDTH(ENT_W), .DEPTH(dbsp_pkg::FIFO_DEPTH)) u_wbuf (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(wr_push),
        .in_ready_o(fifo_in_ready),
        .in_data_i(wr_entry),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(drain),
        .out_data_o(fifo_out)
    );

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    logic [DATA_W-1:0] h0_reg;   // Fetched first word.
    logic [DATA_W-1:0] h1_reg;   // Fetched second word.
    logic pend_reg;              // A fetched burst waits for output.
    logic [DATA_W-1:0] out1_reg; // Second word of the burst on the pins.
    logic second_reg;            // Second word still to be driven.
    logic [DATA_W-1:0] q_reg;    // Read data on the pins.
    logic oe_reg;                // Read drivers enabled.
    logic echo_reg;              // Echo clock.
    // Fetch both words of the location; a high select leaves the address
    // and held words alone.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rd_addr_reg <= '0;
            h0_reg <= '0;
            h1_reg <= '0;
        end
        else if (rd_fetch)
        begin
            rd_addr_reg <= addr_s;
            h0_reg <= arr0_reg[rd_idx];
            h1_reg <= arr1_reg[rd_idx];
        end
    end

    // A new fetch wins over the output edge that empties the slot.
    wire pend_next = rd_fetch | (pend_reg & ~out_pos_rise);
    // Output pos rise drives the first word or floats the bus when no
    // burst waits; the neg rise then drives the second word.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pend_reg <= dbsp_pkg::RST_LOW;
            second_reg <= dbsp_pkg::RST_LOW;
            oe_reg <= dbsp_pkg::RST_LOW;
            q_reg <= '0;
            out1_reg <= '0;
        end
        else
        begin
            pend_reg <= pend_next;
            if (out_pos_rise)
            begin
                oe_reg <= pend_reg;
                second_reg <= pend_reg;
                q_reg <= pend_reg ? h0_reg : q_reg;
                out1_reg <= pend_reg ? h1_reg : out1_reg;
            end
            else if (out_neg_rise && second_reg)
            begin
                q_reg <= out1_reg;
                second_reg <= dbsp_pkg::RST_LOW;
            end
        end
    end

    // Echo follows the output clock, or the input clock in single mode.
    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            echo_reg <= dbsp_pkg::RST_LOW;
        end
        else
        begin
            echo_reg <= single_s ? clk_s[3] : clk_s[1];
        end
    end

    assign read_word_out_o = q_reg;
    assign read_word_oe_o = oe_reg;
    assign echo_timing_o = echo_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    drive_on_pend_a: assert property (out_pos_rise && pend_reg |=> oe_reg)
        else $error("pending burst not driven");
    float_when_idle_a: assert property (out_pos_rise && !pend_reg |=> !oe_reg)
        else $error("bus driven with no burst");
    second_word_a: assert property (out_neg_rise && second_reg && !out_pos_rise
        |=> q_reg == $past(out1_reg))
        else $error("second word wrong");
    write_closed_a: assert property (kp_rise && wsel_n_s |=> !wr_open_reg)
        else $error("write opened while deselected");
    write_first_a: assert property (wr_start |=> wr_open_reg && w0_reg == $past(data_s))
        else $error("first write word not held");
    push_on_neg_a: assert property (wr_push |-> kn_rise && $past(wr_open_reg))
        else $error("write pushed off negative edge");
    read_addr_hold_a: assert property (kp_rise && rsel_n_s |=> $stable(rd_addr_reg))
        else $error("read address taken while deselected");
    fetch_on_pos_a: assert property ($rose(pend_reg) |-> $past(kp_rise))
        else $error("read begun off positive edge");
    echo_follow_a: assert property (!single_s ##1 !single_s |-> echo_reg == $past(clk_s[1]))
        else $error("echo not following output clock");

endmodule : dbsp_port

// *** tb/dbsp_ctrl_model.sv ***
/*
 * Memory controller model for the burst SRAM port: makes the input and
 * output clock pairs and drives selects, address, write data and masks.
 * Assumes clock_i is the bench clock; link clocks run 16 clock_i cycles
 * per period, and every pin change lands 1 ns after a clock_i rise.
 */
`timescale 1ns/100ps
module dbsp_ctrl_model #(
    parameter int SKEW = 2 // Lag of the output clock pair, in clock_i cycles.
) (
    // Bench clock and clock mode.
    input wire logic clock_i,
    input wire logic single_i,
    // Clock pairs towards the device.
    output logic kp_o,
    output logic kn_o,
    output logic cp_o,
    output logic cn_o,
    // Request pins towards the device.
    output logic wsel_n_o,
    output logic rsel_n_o,
    output logic [dbsp_pkg::ADDR_W-1:0] addr_o,
    output logic [dbsp_pkg::DATA_W/dbsp_pkg::LANE_W-1:0] mask_o,
    output logic [dbsp_pkg::DATA_W-1:0] data_o
);
    int cnt = 8; // Phase in the input clock period; starting at 8 keeps kp_o low until the phase wraps to 0.
    event tick; // Fires once the phase has moved.

    // Every pin starts quiet, so nothing is unknown at time zero.
    initial
    begin
        {kp_o, kn_o, cp_o, cn_o} = 4'h2;
        {wsel_n_o, rsel_n_o} = 2'h3;
        addr_o = '0;
        mask_o = '0;
        data_o = '0;
    end

    // Free-running pairs, except the output pair held low in single mode; it lags to mimic board flight time.
    always @(posedge clock_i)
    begin
        #1;
        cnt = (cnt + 1) % 16;
        kp_o = (cnt < 8);
        kn_o = !kp_o;
        cp_o = !single_i && (((cnt - SKEW + 16) % 16) < 8);
        cn_o = !single_i && !cp_o;
        -> tick;
    end

    // Waits until the phase counter reaches the given value.
    task automatic wait_phase(input int n);
        do @(tick); while (cnt != n);
    endtask : wait_phase

    // One input clock period: selects, read address, first write word and masks set up before
    // the positive rise; write address, second word and masks before the negative rise, each held four cycles past it.
    task automatic access(input logic rd, input logic [dbsp_pkg::ADDR_W-1:0] ra,
        input logic wr, input logic [dbsp_pkg::ADDR_W-1:0] wa,
        input logic [dbsp_pkg::DATA_W-1:0] w0, input logic [dbsp_pkg::DATA_W-1:0] w1,
        input logic [1:0] m0, input logic [1:0] m1);
        wait_phase(12);
        rsel_n_o = !rd;
        wsel_n_o = !wr;
        addr_o = ra;
        data_o = w0;
        mask_o = m0;
        wait_phase(4);
        {wsel_n_o, rsel_n_o} = 2'h3;
        addr_o = wa;
        data_o = w1;
        mask_o = m1;
    endtask : access
endmodule : dbsp_ctrl_model

// *** tb/tb_dual_port_ddr_burst_sram_port.sv ***
/*
 * Self-checking bench for the burst SRAM port: writes, masked writes,
 * deselected ports, reads in both clock modes and the echo clock.
 * Assumes the narrow part defaults and the controller model beside it.
 */
`timescale 1ns/100ps
module tb_dual_port_ddr_burst_sram_port;
    localparam int DW = dbsp_pkg::DATA_W;
    localparam logic [DW-1:0] A0 = 18'h1_2345, A1 = 18'h2_6789, B0 = 18'h3_0F0F;
    localparam logic [DW-1:0] B1 = 18'h0_F0F0, C0 = 18'h3_FFFF, C1 = 18'h2_AAAA;
    logic clock_i = 1'h0; // Bench clock, 100 MHz.
    logic rst_n_i = 1'h0; // Held low for the first five cycles.
    logic single = 1'h0; // Clock mode strap.
    logic kp, kn, cp, cn, wsel_n, rsel_n, oe, echo;
    logic [dbsp_pkg::ADDR_W-1:0] addr;
    logic [1:0] mask;
    logic [DW-1:0] wdata, q;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    wire out_pos = single ? kp : cp; // Clock that times the first word out.
    wire out_neg = single ? kn : cn; // Clock that times the second word out.

    dbsp_ctrl_model u_ctrl (.clock_i(clock_i), .single_i(single), .kp_o(kp), .kn_o(kn),
        .cp_o(cp), .cn_o(cn), .wsel_n_o(wsel_n), .rsel_n_o(rsel_n), .addr_o(addr),
        .mask_o(mask), .data_o(wdata));
    dbsp_port u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .primary_timing_pos_i(kp),
        .primary_timing_neg_i(kn), .output_timing_pos_i(cp), .output_timing_neg_i(cn),
        .single_clock_mode_i(single), .write_port_select_n_i(wsel_n),
        .read_port_select_n_i(rsel_n), .addr_i(addr), .byte_lane_mask_n_i(mask),
        .write_word_in_i(wdata), .read_word_out_o(q), .read_word_oe_o(oe),
        .echo_timing_o(echo));

    // ------------------------------------------------------------
    // Clock, timeout and reporting
    // ------------------------------------------------------------
    initial
    begin
        forever #5 clock_i = ~clock_i;
    end

    // A hang is cut short well past the few hundred periods the run needs.
    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            miscompares++;
            report_and_stop();
        end
    end

    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
        begin
            $display("NO MISMATCHES");
        end
        else
        begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    task automatic check_word(input string name, input logic [DW-1:0] exp,
        input logic [DW-1:0] got);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : check_word

    task automatic check_bit(input string name, input logic exp, input logic got);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask : check_bit

    // Waits for the burst, checks both words, then the float after the burst.
    task automatic get_burst(input logic [DW-1:0] e0, input logic [DW-1:0] e1);
        int n;
        n = 0;
        while (oe !== 1'h1 && n < 64)
        begin
            @(negedge clock_i);
            n++;
        end
        check_bit("read enable", 1'h1, oe);
        check_word("first word", e0, q);
        @(posedge out_neg);
        repeat (6) @(negedge clock_i);
        check_word("second word", e1, q);
        @(posedge out_pos);
        repeat (6) @(negedge clock_i);
        check_bit("read enable", 1'h0, oe);
    endtask : get_burst

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Write, then a read and a write in the same period, back to back.
    task automatic t_write_read;
        u_ctrl.access(1'h0, '0, 1'h1, 20'h0_0003, A0, A1, 2'h0, 2'h0);
        u_ctrl.access(1'h1, 20'h0_0003, 1'h1, 20'h0_0005, B0, B1, 2'h0, 2'h0);
        get_burst(A0, A1);
        u_ctrl.access(1'h1, 20'h0_0005, 1'h0, '0, C1, C0, 2'h0, 2'h0);
        get_burst(B0, B1);
    endtask : t_write_read

    // Each lane mask keeps its own byte, separately for each word.
    task automatic t_mask;
        u_ctrl.access(1'h0, '0, 1'h1, 20'h0_0003, C0, C1, 2'h1, 2'h2);
        u_ctrl.access(1'h1, 20'h0_0003, 1'h0, '0, A1, A0, 2'h3, 2'h3);
        get_burst({C0[17:9], A0[8:0]}, {A1[17:9], C1[8:0]});
    endtask : t_mask

    // Deselected ports ignore live data and address on the pins.
    task automatic t_deselect;
        u_ctrl.access(1'h0, 20'h0_0003, 1'h0, 20'h0_0003, B1, B0, 2'h0, 2'h0);
        repeat (16) @(negedge clock_i);
        check_bit("read enable", 1'h0, oe);
        u_ctrl.access(1'h1, 20'h0_0003, 1'h0, '0, A0, A1, 2'h0, 2'h0);
        get_burst({C0[17:9], A0[8:0]}, {A1[17:9], C1[8:0]});
    endtask : t_deselect

    // Echo clock must repeat the clock that times the first word out three cycles late.
    task automatic t_echo;
        logic [2:0] hist;
        hist = '0;
        repeat (3)
        begin
            @(negedge clock_i);
            hist = {hist[1:0], out_pos};
        end
        repeat (40)
        begin
            @(negedge clock_i);
            check_bit("echo clock", hist[2], echo);
            hist = {hist[1:0], out_pos};
        end
    endtask : t_echo

    // In single clock mode the input clocks time the read data and echo.
    task automatic t_single;
        @(posedge clock_i);
        #1 single = 1'h1;
        u_ctrl.access(1'h1, 20'h0_0005, 1'h0, '0, A0, A1, 2'h0, 2'h0);
        get_burst(B0, B1);
        t_echo();
        @(posedge clock_i);
        #1 single = 1'h0;
    endtask : t_single

    // Main sequence: reset, scenarios, verdict.
    initial
    begin
        repeat (5) @(posedge clock_i);
        #1 rst_n_i = 1'h1;
        check_bit("read enable", 1'h0, oe);
        t_write_read();
        t_mask();
        t_deselect();
        t_single();
        t_echo();
        report_and_stop();
    end
endmodule : tb_dual_port_ddr_burst_sram_port
